// [charger_i2c_mode_control.sv]
/*
  Serial slave register bank and mode control of the charger.
  Assumes SCL and SDA arrive from pins, other inputs are on CLOCK,
  and the pad resolves SDA from SDA_OE (open drain, drives low).
*/
module charger_i2c_mode_control
  import charger_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input  wire logic      CLOCK,
  input  wire logic      RESET_N,
  // Serial bus pins
  input  wire logic      SCL_IN,
  input  wire logic      SDA_IN,
  output logic           SDA_OUT,
  output logic           SDA_OE,
  // Charger detection front end
  output logic           DETECT_REQUEST,
  input  wire logic      DETECT_DONE,
  input  wire logic      DETECT_WALL,
  // Status and events from the charger core
  input  wire logic [7:0] STATUS_FIRST_IN,
  input  wire logic [7:0] STATUS_SECOND_IN,
  input  wire event_bytes_t EVENT_SET,
  input  wire logic      CHARGER_ACTIVE,
  // Controls to the power stage
  output charger_config_t CONFIG_OUT,
  output event_bytes_t   EVENT_MASK_OUT,
  output power_control_t POWER_OUT,
  output logic           STAT_PULL_LOW
);

  // Whole module state
  typedef struct packed {
    i2c_state_t      st;
    logic [3:0]      cnt;
    logic [7:0]      shift;
    logic [7:0]      tx;
    logic [7:0]      index;
    logic            rw;
    logic            nack;
    logic            sda_drive;
    logic            scl_q;
    logic            sda_q;
    logic [1:0]      stat_ctrl;
    logic [1:0]      spare;
    logic            ldo;
    logic            trig;
    logic            auto_pend;
    logic [1:0]      mode;
    logic            det_wall;
    charger_config_t cfg;
    event_bytes_t    flags;
    event_bytes_t    masks;
    logic [7:0]      status_first;
    logic [7:0]      status_second;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RST = '{
    st:            ST_IDLE,
    cnt:           4'h0,
    shift:         8'h00,
    tx:            8'h00,
    index:         8'h00,
    rw:            1'b0,
    nack:          1'b0,
    sda_drive:     1'b0,
    scl_q:         1'b1,
    sda_q:         1'b1,
    stat_ctrl:     RST_MODE_CONTROL[STAT_CTRL_LSB +: 2],
    spare:         RST_MODE_CONTROL[SPARE_LSB +: 2],
    ldo:           RST_MODE_CONTROL[LDO_BIT],
    trig:          RST_MODE_CONTROL[TRIGGER_BIT],
    auto_pend:     1'b1,
    mode:          RST_MODE_CONTROL[MODE_LSB +: 2],
    det_wall:      1'b0,
    cfg:           '{safety: RST_SAFETY_CFG, special: RST_SPECIAL_CFG,
                     voltage: RST_VOLTAGE_CFG, current: RST_CURRENT_CFG},
    flags:         '{boost: RST_EVENT, charger: RST_EVENT, general: RST_EVENT},
    masks:         '{boost: RST_EVENT, charger: RST_EVENT, general: RST_EVENT},
    status_first:  RST_STATUS_FIRST,
    status_second: RST_STATUS_SECOND
  };

  ctrl_state_t ctrl_r;
  ctrl_state_t ctrl_nxt;

  logic [1:0] pins_f;
  logic       scl_f;
  logic       sda_f;

  // Register read decode
  function automatic logic [7:0] reg_read(input ctrl_state_t s,
                                          input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_MODE_CONTROL:  v = {s.stat_ctrl, s.spare, s.ldo, s.trig, s.mode};
      IDX_CURRENT_CFG:   v = s.cfg.current;
      IDX_VOLTAGE_CFG:   v = s.cfg.voltage;
      IDX_SPECIAL_CFG:   v = s.cfg.special;
      IDX_SAFETY_CFG:    v = s.cfg.safety;
      IDX_STATUS_FIRST:  v = s.status_first;
      IDX_STATUS_SECOND: v = s.status_second;
      IDX_FLAGS_GENERAL: v = s.flags.general;
      IDX_FLAGS_CHARGER: v = s.flags.charger;
      IDX_FLAGS_BOOST:   v = s.flags.boost;
      IDX_MASK_GENERAL:  v = s.masks.general;
      IDX_MASK_CHARGER:  v = s.masks.charger;
      IDX_MASK_BOOST:    v = s.masks.boost;
      IDX_PART_IDENTITY: v = PART_ID;
      default:           v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // Programmed limit code to effective limit code
  function automatic logic [1:0] prog_to_limit(input logic [1:0] code);
    logic [1:0] v;
    v = LIMIT_100MA;
    case (code)
      PROG_500MA: v = LIMIT_500MA;
      PROG_NONE:  v = LIMIT_NONE;
      default:    v = LIMIT_100MA;
    endcase
    return v;
  endfunction : prog_to_limit

  // Filtered bus pins
  pin_sync #(
    .W           (2),
    .RESET_LEVEL (8'hFF)
  ) u_pin_sync (
    .clk       (CLOCK),
    .rst_n     (RESET_N),
    .pin_in    ({SCL_IN, SDA_IN}),
    .level_out (pins_f)
  );

  assign scl_f = pins_f[1];
  assign sda_f = pins_f[0];

  // Next state
  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       byte_done;
    logic       wr_en;
    logic       rd_take;
    logic [7:0] rd_idx;
    logic [7:0] wdata;
    event_bytes_t cleared;

    ctrl_nxt  = ctrl_r;
    scl_rise  = scl_f & ~ctrl_r.scl_q;
    scl_fall  = ~scl_f & ctrl_r.scl_q;
    start_c   = ctrl_r.scl_q & scl_f & ctrl_r.sda_q & ~sda_f;
    stop_c    = ctrl_r.scl_q & scl_f & ~ctrl_r.sda_q & sda_f;
    byte_done = (ctrl_r.cnt == 4'h8);
    wr_en     = 1'b0;
    rd_take   = 1'b0;
    rd_idx    = ctrl_r.index;
    wdata     = ctrl_r.shift;
    cleared   = ctrl_r.flags;

    ctrl_nxt.scl_q         = scl_f;
    ctrl_nxt.sda_q         = sda_f;
    ctrl_nxt.status_first  = STATUS_FIRST_IN;
    ctrl_nxt.status_second = STATUS_SECOND_IN;

    // Bus framing: stop and start override any bit phase
    if (stop_c) begin
      ctrl_nxt.st        = ST_IDLE;
      ctrl_nxt.sda_drive = 1'b0;
    end else if (start_c) begin
      ctrl_nxt.st        = ST_ADDR;
      ctrl_nxt.cnt       = 4'h0;
      ctrl_nxt.sda_drive = 1'b0;
    end else if (scl_rise) begin
      // Sample a bit while the clock is high
      ctrl_nxt.shift = {ctrl_r.shift[6:0], sda_f};
      if (!byte_done) begin
        ctrl_nxt.cnt = ctrl_r.cnt + 4'h1;
      end
      if (ctrl_r.st == ST_ACK_READ) begin
        ctrl_nxt.nack = sda_f;
      end
    end else if (scl_fall) begin
      // Change the data line while the clock is low
      case (ctrl_r.st)
        ST_ADDR: begin
          if (byte_done) begin
            if (ctrl_r.shift[7:1] == SLAVE_ADDR) begin
              ctrl_nxt.rw        = ctrl_r.shift[0];
              ctrl_nxt.st        = ST_ACK_ADDR;
              ctrl_nxt.sda_drive = 1'b1;
            end else begin
              ctrl_nxt.st = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          ctrl_nxt.cnt = 4'h0;
          if (ctrl_r.rw) begin
            rd_take            = 1'b1;
            ctrl_nxt.tx        = reg_read(ctrl_r, ctrl_r.index);
            ctrl_nxt.sda_drive = ~ctrl_nxt.tx[7];
            ctrl_nxt.index     = ctrl_r.index + 8'h01;
            ctrl_nxt.st        = ST_READ;
          end else begin
            ctrl_nxt.sda_drive = 1'b0;
            ctrl_nxt.st        = ST_INDEX;
          end
        end
        ST_INDEX: begin
          if (byte_done) begin
            ctrl_nxt.index     = ctrl_r.shift;
            ctrl_nxt.st        = ST_ACK_INDEX;
            ctrl_nxt.sda_drive = 1'b1;
          end
        end
        ST_ACK_INDEX: begin
          ctrl_nxt.sda_drive = 1'b0;
          ctrl_nxt.cnt       = 4'h0;
          ctrl_nxt.st        = ST_WRITE;
        end
        ST_WRITE: begin
          if (byte_done) begin
            wr_en              = 1'b1;
            ctrl_nxt.st        = ST_ACK_WRITE;
            ctrl_nxt.sda_drive = 1'b1;
          end
        end
        ST_ACK_WRITE: begin
          ctrl_nxt.sda_drive = 1'b0;
          ctrl_nxt.cnt       = 4'h0;
          ctrl_nxt.index     = ctrl_r.index + 8'h01;
          ctrl_nxt.st        = ST_WRITE;
        end
        ST_READ: begin
          if (byte_done) begin
            ctrl_nxt.sda_drive = 1'b0;
            ctrl_nxt.st        = ST_ACK_READ;
          end else begin
            ctrl_nxt.tx        = {ctrl_r.tx[6:0], 1'b0};
            ctrl_nxt.sda_drive = ~ctrl_r.tx[6];
          end
        end
        ST_ACK_READ: begin
          ctrl_nxt.cnt = 4'h0;
          if (ctrl_r.nack) begin
            ctrl_nxt.st = ST_IDLE;
          end else begin
            rd_take            = 1'b1;
            ctrl_nxt.tx        = reg_read(ctrl_r, ctrl_r.index);
            ctrl_nxt.sda_drive = ~ctrl_nxt.tx[7];
            ctrl_nxt.index     = ctrl_r.index + 8'h01;
            ctrl_nxt.st        = ST_READ;
          end
        end
        ST_IDLE: begin
          ctrl_nxt.sda_drive = 1'b0;
        end
        default: begin
          ctrl_nxt.st        = ST_IDLE;
          ctrl_nxt.sda_drive = 1'b0;
        end
      endcase
    end

    // Reading an event byte clears it; new events set after the clear
    if (rd_take) begin
      case (rd_idx)
        IDX_FLAGS_GENERAL: cleared.general = 8'h00;
        IDX_FLAGS_CHARGER: cleared.charger = 8'h00;
        IDX_FLAGS_BOOST:   cleared.boost   = 8'h00;
        default:           cleared = ctrl_r.flags;
      endcase
    end
    ctrl_nxt.flags = cleared | EVENT_SET;

    // Detection completion ends both automatic and host requests
    if (DETECT_DONE && (ctrl_r.trig || ctrl_r.auto_pend)) begin
      ctrl_nxt.det_wall  = DETECT_WALL;
      ctrl_nxt.trig      = 1'b0;
      ctrl_nxt.auto_pend = 1'b0;
    end

    // Register writes; read-only and unmapped indexes drop the data
    if (wr_en) begin
      case (ctrl_r.index)
        IDX_MODE_CONTROL: begin
          ctrl_nxt.stat_ctrl = wdata[STAT_CTRL_LSB +: 2];
          ctrl_nxt.spare     = wdata[SPARE_LSB +: 2];
          ctrl_nxt.ldo       = wdata[LDO_BIT];
          ctrl_nxt.mode      = wdata[MODE_LSB +: 2];
          if (wdata[TRIGGER_BIT]) begin
            ctrl_nxt.trig = 1'b1;
          end
        end
        IDX_CURRENT_CFG:  ctrl_nxt.cfg.current   = wdata;
        IDX_VOLTAGE_CFG:  ctrl_nxt.cfg.voltage   = wdata;
        IDX_SPECIAL_CFG:  ctrl_nxt.cfg.special   = wdata;
        IDX_SAFETY_CFG:   ctrl_nxt.cfg.safety    = wdata;
        IDX_MASK_GENERAL: ctrl_nxt.masks.general = wdata;
        IDX_MASK_CHARGER: ctrl_nxt.masks.charger = wdata;
        IDX_MASK_BOOST:   ctrl_nxt.masks.boost   = wdata;
        default: begin
          ctrl_nxt.masks = ctrl_r.masks;
        end
      endcase
    end
  end

  // State register with default load
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      ctrl_r <= CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Bus pin drive, open drain
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = ctrl_r.sda_drive;

  // Detection request held until the front end reports done
  assign DETECT_REQUEST = ctrl_r.trig | ctrl_r.auto_pend;

  // Configuration and masks
  assign CONFIG_OUT     = ctrl_r.cfg;
  assign EVENT_MASK_OUT = ctrl_r.masks;

  // Mode decode and input current limit
  always_comb begin
    logic       charging;
    logic [1:0] prog_lim;
    logic [1:0] det_lim;

    charging = (ctrl_r.mode == MODE_CHARGE) || (ctrl_r.mode == MODE_RECHARGE);
    prog_lim = prog_to_limit(ctrl_r.cfg.voltage[PROG_LIMIT_LSB +: 2]);
    det_lim  = ctrl_r.det_wall ? LIMIT_1A : LIMIT_500MA;

    POWER_OUT             = '0;
    POWER_OUT.charge_en   = charging;
    POWER_OUT.boost_en    = (ctrl_r.mode == MODE_BOOST);
    POWER_OUT.recharge_en = (ctrl_r.mode == MODE_RECHARGE);
    POWER_OUT.standby     = (ctrl_r.mode == MODE_STANDBY);
    POWER_OUT.linear_regulator_enable      = ctrl_r.ldo;
    POWER_OUT.input_limit = prog_lim;
    if (charging && !ctrl_r.cfg.current[LIMIT_SRC_BIT] && (det_lim > prog_lim)) begin
      POWER_OUT.input_limit = det_lim;
    end
  end

  // Status pin: automatic follows charging, 10 and 11 release the pin
  always_comb begin
    case (ctrl_r.stat_ctrl)
      STAT_AUTO: STAT_PULL_LOW = CHARGER_ACTIVE;
      STAT_LOW:  STAT_PULL_LOW = 1'b1;
      default:   STAT_PULL_LOW = 1'b0;
    endcase
  end

endmodule : charger_i2c_mode_control

// [charger_i2c_mode_control_bench.sv]
/* Self-checking bench for the charger register bank and mode control.
   Assumes the host model and the bound port checker. */
module charger_i2c_mode_control_bench
  import charger_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h3C;  // Arbitrary value
  logic clk = 1'b0, rst_n = 1'b0, done = 1'b0, wall = 1'b0, act = 1'b0;
  logic [7:0] st1 = 8'h00, st2 = 8'h00, rd, v;
  logic [7:0] tab [15], h [3], e [3];
  logic [7:0] expq [$];
  logic [2:0] nak;
  logic scl, sdd, sda, sdo, oe, req, rv, spl;
  event_bytes_t ev = '0, msk;
  charger_config_t cfg;
  power_control_t pwr;
  int n_fail = 0, tests_run = 0;
  // Clock and open-drain wire with pull-up
  always #10 clk = ~clk;
  assign sda = sdd & ~oe;
  charger_i2c_mode_control #(.PART_ID(ID)) i_charger_i2c_mode_control (
    .CLOCK(clk), .RESET_N(rst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sdo), .SDA_OE(oe),
    .DETECT_REQUEST(req), .DETECT_DONE(done), .DETECT_WALL(wall), .STATUS_FIRST_IN(st1),
    .STATUS_SECOND_IN(st2), .EVENT_SET(ev), .CHARGER_ACTIVE(act), .CONFIG_OUT(cfg),
    .EVENT_MASK_OUT(msk), .POWER_OUT(pwr), .STAT_PULL_LOW(spl));
  i2c_host_model i_i2c_host_model (.clk(clk), .sda_wire(sda), .scl(scl), .sda_drv(sdd),
    .rd_valid(rv), .rd_data(rd));
  task automatic check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] idx, d);
    i_i2c_host_model.write_reg(SLAVE_ADDR, idx, d, nak);
    check("ack", nak, 3'h0);
  endtask : wr
  task automatic rdq(input logic [7:0] idx, x);
    expq.push_back(x);
    i_i2c_host_model.read_regs(idx, 1);
  endtask : rdq
  // One-cycle detection finish pulse
  task automatic detect(input logic w);
    wall = w;
    done = 1'b1;
    @(posedge clk);
    #1 done = 1'b0;
    @(posedge clk);
    #1;
  endtask : detect
  // Compare each read byte with the oldest note
  always @(posedge clk)
    if (rv === 1'b1) begin
      if (expq.size() == 0) check("extra read", 32'h0, 32'h1);
      else check("read", rd, expq.pop_front());
    end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    test_done();
  end
  // Main sequence
  initial begin
    void'($urandom(1));
    st1 = $urandom;
    st2 = $urandom;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    #1 check("detect pending", req, 1'h1);
    tab = '{RST_MODE_CONTROL, RST_CURRENT_CFG, RST_VOLTAGE_CFG, RST_SPECIAL_CFG, RST_SAFETY_CFG,
            8'h00, st1, st2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, ID};
    foreach (tab[i]) expq.push_back(tab[i]);
    i_i2c_host_model.read_regs(IDX_MODE_CONTROL, 15);
    // Foreign address is ignored
    i_i2c_host_model.write_reg(7'h4B, IDX_MODE_CONTROL, 8'h00, nak);
    check("foreign ack", nak[2], 1'h1);
    check("mode kept", pwr, 7'h45);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_MODE_CONTROL, {6'h02, m[1:0]});
      check("modes", pwr[6:2], {m[1], m == 1, m == 3, m == 0, 1'b1});
    end
    for (int s = 0; s < 4; s++) begin
      act = $urandom;
      wr(IDX_MODE_CONTROL, {s[1:0], 6'h0A});
      check("stat pin", spl, s == 0 ? act : s == 1);
    end
    wr(IDX_MODE_CONTROL, RST_MODE_CONTROL);
    check("limit std", pwr.input_limit, LIMIT_500MA);
    detect(1'b1);
    check("detect end", req, 1'h0);
    check("limit wall", pwr.input_limit, LIMIT_1A);
    // Programmed no-limit outranks the wall result
    wr(IDX_VOLTAGE_CFG, 8'hD9);
    check("limit none", pwr.input_limit, LIMIT_NONE);
    wr(IDX_VOLTAGE_CFG, RST_VOLTAGE_CFG);
    wr(IDX_CURRENT_CFG, 8'h81);
    check("limit prog", pwr.input_limit, LIMIT_100MA);
    wr(IDX_CURRENT_CFG, RST_CURRENT_CFG);
    // Wall result is not applied outside charge modes
    wr(IDX_MODE_CONTROL, 8'h09);
    check("limit boost", pwr.input_limit, LIMIT_100MA);
    wr(IDX_MODE_CONTROL, 8'h0E);
    check("trigger", req, 1'h1);
    detect(1'b0);
    rdq(IDX_MODE_CONTROL, RST_MODE_CONTROL);
    check("limit port", pwr.input_limit, LIMIT_500MA);
    // Holes and read-only places drop writes
    v = $urandom;
    h = '{8'h05, 8'h0F, IDX_STATUS_FIRST};
    e = '{8'h00, 8'h00, st1};
    for (int i = 0; i < 3; i++) begin
      wr(h[i], v);
      rdq(h[i], e[i]);
    end
    // Event flag set, read, cleared; mask stored
    v = $urandom;
    ev.charger = v;
    @(posedge clk);
    #1 ev = '0;
    rdq(IDX_FLAGS_CHARGER, v);
    rdq(IDX_FLAGS_CHARGER, 8'h00);
    wr(IDX_MASK_BOOST, v);
    check("mask", msk.boost, v);
    // Slow master writes a configuration byte
    i_i2c_host_model.half = 40;
    v = $urandom;
    wr(IDX_SAFETY_CFG, v);
    check("config", cfg.safety, v);
    i_i2c_host_model.half = 20;
    // Second reset in mid-run
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (8) @(posedge clk);
    #1 check("reset cfg", cfg, {RST_SAFETY_CFG, RST_SPECIAL_CFG, RST_VOLTAGE_CFG,
                                RST_CURRENT_CFG});
    check("reset detect", req, 1'h1);
    check("notes left", 32'(expq.size()), 32'h0);
    test_done();
  end
endmodule : charger_i2c_mode_control_bench

// [charger_i2c_mode_control_props.sv]
/* Port checker for the charger register bank and mode control.
   Assumes it is bound onto charger_i2c_mode_control. */
module charger_props
  import charger_pkg::*;
(
  // Clock, reset and watched ports
  input wire logic            CLOCK,
  input wire logic            RESET_N,
  input wire logic            SCL_IN,
  input wire logic            SDA_OUT,
  input wire logic            SDA_OE,
  input wire logic            DETECT_REQUEST,
  input wire logic            DETECT_DONE,
  input wire charger_config_t CONFIG_OUT,
  input wire event_bytes_t    EVENT_MASK_OUT,
  input wire power_control_t  POWER_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // Detection finish seen one edge back
  sequence done_seen;
    $past(DETECT_DONE);
  endsequence
  // Reset release with every default in place
  sequence reset_state;
    DETECT_REQUEST && !SDA_OE && POWER_OUT == 7'h45 && EVENT_MASK_OUT == 24'h00_0000
      && CONFIG_OUT == {RST_SAFETY_CFG, RST_SPECIAL_CFG, RST_VOLTAGE_CFG, RST_CURRENT_CFG};
  endsequence
  sda_value_a: assert property (SDA_OUT == 1'b0)
    else $error("data pin value not low");
  reset_state_a: assert property ($rose(RESET_N) |-> reset_state)
    else $error("defaults missing after reset");
  modes_apart_a: assert property ($onehot({POWER_OUT.charge_en, POWER_OUT.boost_en, POWER_OUT.standby}))
    else $error("not exactly one mode");
  standby_quiet_a: assert property (POWER_OUT.standby |-> !POWER_OUT.recharge_en && !POWER_OUT.boost_en)
    else $error("standby still active");
  recharge_only_a: assert property (POWER_OUT.recharge_en |-> POWER_OUT.charge_en)
    else $error("recharge outside charge");
  wall_limit_a: assert property (POWER_OUT.input_limit == LIMIT_1A |-> POWER_OUT.charge_en)
    else $error("wall limit outside charge");
  ack_stands_a: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("data drive moved with clock high");
  detect_clear_a: assert property ($fell(DETECT_REQUEST) |-> done_seen)
    else $error("request dropped without finish");
endmodule : charger_props

bind charger_i2c_mode_control charger_props i_charger_props (.CLOCK, .RESET_N, .SCL_IN,
  .SDA_OUT, .SDA_OE, .DETECT_REQUEST, .DETECT_DONE, .CONFIG_OUT, .EVENT_MASK_OUT, .POWER_OUT);

// [charger_pkg.sv]
/*
  Shared constants and carrier types for the charger I2C register bank and mode control.
  Assumes one 50 MHz clock and a synchronous active-low reset at the top level.
*/
package charger_pkg;

  // Bus address
  localparam logic [6:0] SLAVE_ADDR = 7'h4A;

  // Register indexes
  localparam logic [7:0] IDX_MODE_CONTROL  = 8'h00;
  localparam logic [7:0] IDX_CURRENT_CFG   = 8'h01;
  localparam logic [7:0] IDX_VOLTAGE_CFG   = 8'h02;
  localparam logic [7:0] IDX_SPECIAL_CFG   = 8'h03;
  localparam logic [7:0] IDX_SAFETY_CFG    = 8'h04;
  localparam logic [7:0] IDX_STATUS_FIRST  = 8'h06;
  localparam logic [7:0] IDX_STATUS_SECOND = 8'h07;
  localparam logic [7:0] IDX_FLAGS_GENERAL = 8'h08;
  localparam logic [7:0] IDX_FLAGS_CHARGER = 8'h09;
  localparam logic [7:0] IDX_FLAGS_BOOST   = 8'h0A;
  localparam logic [7:0] IDX_MASK_GENERAL  = 8'h0B;
  localparam logic [7:0] IDX_MASK_CHARGER  = 8'h0C;
  localparam logic [7:0] IDX_MASK_BOOST    = 8'h0D;
  localparam logic [7:0] IDX_PART_IDENTITY = 8'h0E;

  // Reset values
  localparam logic [7:0] RST_MODE_CONTROL  = 8'h0A;
  localparam logic [7:0] RST_CURRENT_CFG   = 8'h01;
  localparam logic [7:0] RST_VOLTAGE_CFG   = 8'h19;
  localparam logic [7:0] RST_SPECIAL_CFG   = 8'h02;
  localparam logic [7:0] RST_SAFETY_CFG    = 8'h40;
  localparam logic [7:0] RST_STATUS_FIRST  = 8'h00;
  localparam logic [7:0] RST_STATUS_SECOND = 8'h01;
  localparam logic [7:0] RST_EVENT         = 8'h00;

  // Field positions
  localparam int STAT_CTRL_LSB  = 6;
  localparam int SPARE_LSB      = 4;
  localparam int LDO_BIT        = 3;
  localparam int TRIGGER_BIT    = 2;
  localparam int MODE_LSB       = 0;
  localparam int LIMIT_SRC_BIT  = 7;
  localparam int PROG_LIMIT_LSB = 6;

  // Mode field codes
  localparam logic [1:0] MODE_STANDBY  = 2'h0;
  localparam logic [1:0] MODE_BOOST    = 2'h1;
  localparam logic [1:0] MODE_CHARGE   = 2'h2;
  localparam logic [1:0] MODE_RECHARGE = 2'h3;

  // Status pin field codes
  localparam logic [1:0] STAT_AUTO = 2'h0;
  localparam logic [1:0] STAT_LOW  = 2'h1;

  // Programmed limit codes
  localparam logic [1:0] PROG_100MA = 2'h0;
  localparam logic [1:0] PROG_500MA = 2'h1;
  localparam logic [1:0] PROG_NONE  = 2'h3;

  // Effective limit codes, ordered so a larger code is a larger limit
  localparam logic [1:0] LIMIT_100MA = 2'h0;
  localparam logic [1:0] LIMIT_500MA = 2'h1;
  localparam logic [1:0] LIMIT_1A    = 2'h2;
  localparam logic [1:0] LIMIT_NONE  = 2'h3;

  // Configuration bytes as driven to the analog loops
  typedef struct packed {
    logic [7:0] safety;
    logic [7:0] special;
    logic [7:0] voltage;
    logic [7:0] current;
  } charger_config_t;

  // One byte per event group
  typedef struct packed {
    logic [7:0] boost;
    logic [7:0] charger;
    logic [7:0] general;
  } event_bytes_t;

  // Power stage controls
  typedef struct packed {
    logic       charge_en;
    logic       boost_en;
    logic       recharge_en;
    logic       standby;
    logic       linear_regulator_enable;
    logic [1:0] input_limit;
  } power_control_t;

  // Serial slave states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_INDEX, ST_ACK_INDEX,
    ST_WRITE, ST_ACK_WRITE, ST_READ, ST_ACK_READ
  } i2c_state_t;

endpackage : charger_pkg

// [i2c_host_model.sv]
/* Bus master model that bit-bangs the serial pins.
   Assumes the bench resolves the open-drain data wire with a pull-up. */
module i2c_host_model
  import charger_pkg::*;
(
  // Clock and resolved data wire
  input  wire logic clk,
  input  wire logic sda_wire,
  // Pins and read results
  output logic       scl,
  output logic       sda_drv,
  output logic       rd_valid,
  output logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 20;  // Clock half period in cycles, raised for a slow master
  // Bus idle at time zero
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rd_valid = 1'b0;
    rd_data = 8'h00;
  end
  // Wait cycles, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Start or repeated start: data falls with clock high
  task automatic start();
    sda_drv = 1'b1;
    tick(half / 2);
    scl = 1'b1;
    tick(half);
    sda_drv = 1'b0;
    tick(half);
    scl = 1'b0;
    tick(half / 2);
  endtask : start
  // Stop: data rises with clock high
  task automatic stop();
    sda_drv = 1'b0;
    tick(half / 2);
    scl = 1'b1;
    tick(half);
    sda_drv = 1'b1;
    tick(half);
  endtask : stop
  // One bit, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    tick(half / 2);
    scl = 1'b1;
    tick(half / 2);
    r = sda_wire;
    tick(half / 2);
    scl = 1'b0;
    tick(half / 2);
  endtask : bit_io
  // Byte MSB first, then the acknowledge bit
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                         output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, ack);
  endtask : byte_io
  // Address with write direction, index, data
  task automatic write_reg(input logic [6:0] a, input logic [7:0] idx, d, output logic [2:0] nak);
    logic [7:0] q;
    start();
    byte_io({a, 1'b0}, 1'b1, q, nak[2]);
    byte_io(idx, 1'b1, q, nak[1]);
    byte_io(d, 1'b1, q, nak[0]);
    stop();
  endtask : write_reg
  // Index set, repeated start, n bytes, last one refused
  task automatic read_regs(input logic [7:0] idx, input int n);
    logic [7:0] q;
    logic       k;
    start();
    byte_io({SLAVE_ADDR, 1'b0}, 1'b1, q, k);
    byte_io(idx, 1'b1, q, k);
    start();
    byte_io({SLAVE_ADDR, 1'b1}, 1'b1, q, k);
    for (int i = 0; i < n; i++) begin
      byte_io(8'hFF, i == n - 1, q, k);
      rd_data = q;
      rd_valid = 1'b1;
      tick(1);
      rd_valid = 1'b0;
    end
    stop();
  endtask : read_regs
endmodule : i2c_host_model

// [pin_sync.sv]
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes asynchronous pin levels and the top-level clock and reset.
*/
module pin_sync
  import charger_pkg::*;
#(
  parameter int         W           = 2,
  parameter logic [7:0] RESET_LEVEL = 8'hFF
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins and filtered levels
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } sync_state_t;

  localparam logic [W-1:0] LVL = RESET_LEVEL[W-1:0];
  localparam sync_state_t SYNC_RST = '{s1: LVL, s2: LVL, s3: LVL, level: LVL};

  sync_state_t sync_r;
  sync_state_t sync_nxt;

  // Width check
  if (W < 1 || W > 8) begin : g_bad_width
    $error("pin_sync width must be 1 to 8");
  end

  // Shift chain; level moves only when stages two and three agree
  always_comb begin
    sync_nxt    = sync_r;
    sync_nxt.s1 = pin_in;
    sync_nxt.s2 = sync_r.s1;
    sync_nxt.s3 = sync_r.s2;
    for (int i = 0; i < W; i++) begin
      if (sync_r.s2[i] == sync_r.s3[i]) begin
        sync_nxt.level[i] = sync_r.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_r <= SYNC_RST;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign level_out = sync_r.level;

endmodule : pin_sync
